// ### kbc_pkg.sv
package kbc_pkg;
	localparam logic [7:0] ADDR_DATA    = 8'h60;
	localparam logic [7:0] ADDR_CMD     = 8'h64;
	localparam logic [7:0] CMD_RD_CB    = 8'h20;
	localparam logic [7:0] CMD_WR_CB    = 8'h60;
	localparam logic [7:0] CMD_SELF     = 8'haa;
	localparam logic [7:0] CMD_LINE     = 8'hab;
	localparam logic [7:0] CMD_DUMP     = 8'hac;
	localparam logic [7:0] CMD_DIS      = 8'had;
	localparam logic [7:0] CMD_ENA      = 8'hae;
	localparam logic [7:0] CMD_RD_IN    = 8'hc0;
	localparam logic [7:0] CMD_RD_OUT   = 8'hd0;
	localparam logic [7:0] CMD_WR_OUT   = 8'hd1;
	localparam logic [7:0] CMD_RD_TEST  = 8'he0;
	localparam logic [3:0] CMD_PULSE_HI = 4'hf;
	localparam logic [7:0] RES_SELF_OK  = 8'h55;
	localparam logic [7:0] RES_LINE_OK  = 8'h00;
	localparam logic [7:0] RES_CLK_LOW  = 8'h01;
	localparam logic [7:0] RES_DAT_LOW  = 8'h03;
	localparam logic [7:0] RES_TX_ERR   = 8'hfe;
	localparam logic [7:0] RES_RX_ERR   = 8'hff;
	localparam logic [7:0] BREAK_PREFIX = 8'hf0;
	localparam logic [7:0] CB_RESET     = 8'h00;
	localparam logic [3:0] OP_RESET     = 4'h3;
	localparam int CB_INT  = 0;
	localparam int CB_SYS  = 2;
	localparam int CB_OVR  = 3;
	localparam int CB_DIS  = 4;
	localparam int CB_PC   = 5;
	localparam int CB_XLAT = 6;
	localparam logic [3:0] FR_DATA_END = 4'd8;
	localparam logic [3:0] FR_PAR      = 4'd9;
	localparam logic [3:0] FR_STOP     = 4'd10;
	localparam logic [3:0] FR_ACK      = 4'd11;
	localparam logic [5:0] DUMP_LAST   = 6'd37;
	localparam logic [3:0] DUMP_IN     = 4'd0;
	localparam logic [3:0] DUMP_OUT    = 4'd1;
	localparam int CLK_MHZ     = 100;
	localparam int T_START_MS  = 15;
	localparam int T_FINISH_MS = 2;
	localparam int T_RESP_MS   = 25;
	localparam int T_PULSE_MS  = 6;
	localparam int T_INHIB_US  = 100;
	localparam int START_CYC   = T_START_MS * 1000 * CLK_MHZ;
	localparam int FINISH_CYC  = T_FINISH_MS * 1000 * CLK_MHZ;
	localparam int RESP_CYC    = T_RESP_MS * 1000 * CLK_MHZ;
	localparam int PULSE_CYC   = T_PULSE_MS * 1000 * CLK_MHZ;
	localparam int INHIB_CYC   = T_INHIB_US * CLK_MHZ;
	localparam int ABORT_CYC   = 4;
	localparam int TMR_W       = 22;
	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_TXINH = 4'h1,
		S_TXRUN = 4'h2,
		S_RESP  = 4'h3,
		S_RXRUN = 4'h4,
		S_PULSE = 4'h5,
		S_DUMP  = 4'h6,
		S_ABORT = 4'h7
	} kbc_state_e;
endpackage

// ### kbc_top.sv
`timescale 1ns/1ns
module kbc_top #(
	parameter int unsigned START_CYC  = kbc_pkg::START_CYC,
	parameter int unsigned FINISH_CYC = kbc_pkg::FINISH_CYC,
	parameter int unsigned RESP_CYC   = kbc_pkg::RESP_CYC,
	parameter int unsigned PULSE_CYC  = kbc_pkg::PULSE_CYC,
	parameter int unsigned INHIB_CYC  = kbc_pkg::INHIB_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] io_addr_i,
	input  wire logic       io_rd_i,
	input  wire logic       io_wr_i,
	input  wire logic [7:0] io_wdata_i,
	output logic      [7:0] io_rdata_o,
	input  wire logic       keyboard_serial_clock_i,
	output logic            keyboard_serial_clock_o,
	output logic            keyboard_serial_clock_oe_o,
	input  wire logic       keyboard_serial_line_i,
	output logic            keyboard_serial_line_o,
	output logic            keyboard_serial_line_oe_o,
	input  wire logic       inhibit_switch_i,
	input  wire logic       display_switch_i,
	output logic            cpu_reset_n_o,
	output logic            high_address_line_gate_o,
	output logic            obuf_irq_o
);
	import kbc_pkg::*;

	typedef struct packed {
		kbc_state_e        st;
		logic [TMR_W-1:0]  tmr;
		logic [7:0]        obuf;
		logic              obf;
		logic [7:0]        ibuf;
		logic              ibf;
		logic              cd;
		logic              inh;
		logic              tto;
		logic              rto;
		logic              par;
		logic [7:0]        cb;
		logic [3:0]        op;
		logic [3:0]        pulse;
		logic [7:0]        pend;
		logic [7:0]        txd;
		logic              txreq;
		logic              abort;
		logic              brk;
		logic [5:0]        idx;
		logic [15:0][7:0]  ram;
		logic [7:0]        rdata;
		logic              irq;
		logic              clk_oe;
		logic              rst_n;
		logic              a20;
		logic [3:0]        pin1;
		logic [3:0]        pin2;
		logic              kc3;
		logic              rt1;
		logic              rt2;
		logic              rx_seen;
		logic              tt1;
		logic              tt2;
	} kbc_sys_s;

	typedef struct packed {
		logic [3:0] cnt;
		logic       tx;
		logic [7:0] sh;
		logic       par;
		logic [7:0] rx_byte;
		logic       rx_perr;
		logic       rx_tgl;
		logic       tx_tgl;
		logic       doe;
	} kbc_lnk_s;

	kbc_sys_s s_q;
	kbc_sys_s s_d;
	kbc_lnk_s l_q;
	kbc_lnk_s l_d;
	logic     lnk_rst_n;

	function automatic logic [7:0] hex_scan(input logic [3:0] n);
		logic [7:0] v;
		v = 8'h00;
		case (n)
			4'h0: v = 8'h45;
			4'h1: v = 8'h16;
			4'h2: v = 8'h1e;
			4'h3: v = 8'h26;
			4'h4: v = 8'h25;
			4'h5: v = 8'h2e;
			4'h6: v = 8'h36;
			4'h7: v = 8'h3d;
			4'h8: v = 8'h3e;
			4'h9: v = 8'h46;
			4'ha: v = 8'h1c;
			4'hb: v = 8'h32;
			4'hc: v = 8'h21;
			4'hd: v = 8'h23;
			4'he: v = 8'h24;
			default: v = 8'h2b;
		endcase
		return v;
	endfunction

	// Load the output buffer; inhibit bit follows the switch on every load
	function automatic kbc_sys_s put(input kbc_sys_s s, input logic [7:0] v);
		kbc_sys_s r;
		r = s;
		r.obuf = v;
		r.obf = 1'b1;
		r.inh = s.pin2[3];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Link side, on the keyboard's own clock
	// Abort only resets the link once the frame is abandoned by the host side
	assign lnk_rst_n = resetn_i & ~s_q.abort;

	always_comb begin
		l_d = l_q;
		if (l_q.cnt == 4'd0) begin
			// Request toggle and byte are held still for half an inhibit period before the clock is pulled low
			if (s_q.txreq != l_q.tx_tgl) begin
				l_d.tx = 1'b1;
				l_d.doe = 1'b1;
				l_d.sh = s_q.txd;
				l_d.par = 1'b0;
				l_d.cnt = 4'd1;
			end else if (!keyboard_serial_line_i) begin
				l_d.tx = 1'b0;
				l_d.par = 1'b0;
				l_d.cnt = 4'd1;
			end
		end else if (l_q.tx) begin
			l_d.cnt = l_q.cnt + 4'd1;
			if (l_q.cnt <= FR_DATA_END) begin
				l_d.doe = ~l_q.sh[0];
				l_d.par = l_q.par ^ l_q.sh[0];
				l_d.sh = {1'b0, l_q.sh[7:1]};
			end else if (l_q.cnt == FR_PAR) begin
				l_d.doe = l_q.par;
			end else if (l_q.cnt == FR_STOP) begin
				l_d.doe = 1'b0;
			end else begin
				l_d.tx_tgl = ~l_q.tx_tgl;
				l_d.cnt = 4'd0;
			end
		end else begin
			l_d.cnt = l_q.cnt + 4'd1;
			if (l_q.cnt <= FR_PAR) begin
				l_d.par = l_q.par ^ keyboard_serial_line_i;
			end
			if (l_q.cnt <= FR_DATA_END) begin
				l_d.sh = {keyboard_serial_line_i, l_q.sh[7:1]};
			end
			if (l_q.cnt == FR_STOP) begin
				l_d.rx_byte = l_q.sh;
				l_d.rx_perr = ~l_q.par;
				l_d.rx_tgl = ~l_q.rx_tgl;
				l_d.cnt = 4'd0;
			end
		end
	end

	always_ff @(negedge keyboard_serial_clock_i or negedge lnk_rst_n) begin
		if (!lnk_rst_n) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Host side
	always_comb begin
		logic       rx_ev;
		logic [7:0] rxb;
		logic [7:0] item;
		logic [7:0] inport;
		logic [7:0] outport;
		s_d = s_q;
		rx_ev = s_q.rt2 != s_q.rx_seen;
		rxb = l_q.rx_byte;
		inport = {s_q.pin2[3], s_q.pin2[2], 6'h00};
		outport = {s_q.pin2[0], s_q.pin2[1], 1'b0, s_q.obf, s_q.op};
		item = 8'h00;
		s_d.kc3 = s_q.pin2[1];
		s_d.rt1 = l_q.rx_tgl;
		s_d.rt2 = s_q.rt1;
		s_d.tt1 = l_q.tx_tgl;
		s_d.tt2 = s_q.tt1;
		if (s_q.st != S_ABORT) begin
			s_d.rx_seen = s_q.rt2;
		end
		if (s_q.tmr != '0) begin
			s_d.tmr = s_q.tmr - 1'b1;
		end
		s_d.rdata = 8'h00;
		if (io_rd_i && io_addr_i == ADDR_DATA) begin
			s_d.rdata = s_q.obuf;
			s_d.obf = 1'b0;
		end else if (io_rd_i && io_addr_i == ADDR_CMD) begin
			s_d.rdata = {s_q.par, s_q.rto, s_q.tto, s_q.inh,
				s_q.cd, s_q.cb[CB_SYS], s_q.ibf, s_q.obf};
		end
		case (s_q.st)
			S_IDLE: begin
				if (s_q.ibf && s_q.cd) begin
					s_d.ibf = 1'b0;
					s_d.pend = 8'h00;
					case (s_q.ibuf)
						CMD_RD_CB: s_d = put(s_d, s_q.cb);
						CMD_WR_CB: s_d.pend = s_q.ibuf;
						CMD_WR_OUT: s_d.pend = s_q.ibuf;
						CMD_SELF: s_d = put(s_d, RES_SELF_OK);
						CMD_LINE: begin
							// Stuck-high faults need a driven test and are not detected
							if (!s_q.pin2[1] && !s_q.clk_oe) begin
								s_d = put(s_d, RES_CLK_LOW);
							end else if (!s_q.pin2[0]) begin
								s_d = put(s_d, RES_DAT_LOW);
							end else begin
								s_d = put(s_d, RES_LINE_OK);
							end
						end
						CMD_DUMP: begin
							s_d.idx = 6'd0;
							s_d.st = S_DUMP;
						end
						CMD_DIS: s_d.cb[CB_DIS] = 1'b1;
						CMD_ENA: s_d.cb[CB_DIS] = 1'b0;
						CMD_RD_IN: s_d = put(s_d, inport);
						CMD_RD_OUT: s_d = put(s_d, outport);
						CMD_RD_TEST: s_d = put(s_d, {6'h00, s_q.pin2[0], s_q.pin2[1]});
						default: begin
							if (s_q.ibuf[7:4] == CMD_PULSE_HI) begin
								s_d.pulse = ~s_q.ibuf[3:0];
								s_d.tmr = TMR_W'(PULSE_CYC);
								s_d.st = S_PULSE;
							end
						end
					endcase
				end else if (s_q.ibf) begin
					s_d.ibf = 1'b0;
					s_d.pend = 8'h00;
					if (s_q.pend == CMD_WR_CB) begin
						s_d.cb = s_q.ibuf;
					end else if (s_q.pend == CMD_WR_OUT) begin
						s_d.op = s_q.ibuf[3:0];
					end else if (s_q.cb[CB_DIS]) begin
						s_d.tto = 1'b1;
						s_d = put(s_d, RES_TX_ERR);
					end else begin
						s_d.txd = s_q.ibuf;
						s_d.tto = 1'b0;
						s_d.rto = 1'b0;
						s_d.par = 1'b0;
						s_d.txreq = ~s_q.txreq;
						s_d.tmr = TMR_W'(INHIB_CYC);
						s_d.st = S_TXINH;
					end
				end else if (s_q.kc3 && !s_q.pin2[1] && !s_q.clk_oe) begin
					s_d.tmr = TMR_W'(FINISH_CYC);
					s_d.st = S_RXRUN;
				end
			end
			S_TXINH: begin
				if (s_q.tmr == '0) begin
					s_d.tmr = TMR_W'(START_CYC + FINISH_CYC);
					s_d.st = S_TXRUN;
				end
			end
			S_TXRUN: begin
				if (s_q.tt2 == s_q.txreq) begin
					s_d.tmr = TMR_W'(RESP_CYC);
					s_d.st = S_RESP;
				end else if (s_q.tmr == '0) begin
					s_d.tto = 1'b1;
					s_d = put(s_d, RES_TX_ERR);
					s_d.tmr = TMR_W'(ABORT_CYC);
					s_d.st = S_ABORT;
				end
			end
			S_RESP: begin
				if (rx_ev) begin
					s_d.st = S_IDLE;
					if (l_q.rx_perr && !s_q.cb[CB_PC]) begin
						s_d.tto = 1'b1;
						s_d.par = 1'b1;
						s_d = put(s_d, RES_TX_ERR);
					end else begin
						s_d = put(s_d, rxb);
					end
				end else if (s_q.tmr == '0) begin
					s_d.tto = 1'b1;
					s_d.rto = 1'b1;
					s_d = put(s_d, RES_TX_ERR);
					s_d.tmr = TMR_W'(ABORT_CYC);
					s_d.st = S_ABORT;
				end
			end
			S_RXRUN: begin
				if (rx_ev) begin
					s_d.st = S_IDLE;
					s_d.ram = {s_q.ram[14:0], rxb};
					s_d.par = l_q.rx_perr;
					s_d.rto = 1'b0;
					if (l_q.rx_perr && !s_q.cb[CB_PC]) begin
						s_d = put(s_d, RES_RX_ERR);
					end else if (!s_q.pin2[3] && !s_q.cb[CB_OVR]) begin
						s_d.brk = 1'b0;
					end else if (s_q.cb[CB_XLAT] && !s_q.cb[CB_PC]) begin
						if (rxb == BREAK_PREFIX) begin
							s_d.brk = 1'b1;
						end else begin
							s_d.brk = 1'b0;
							s_d = put(s_d, {s_q.brk | rxb[7], rxb[6:0]});
						end
					end else begin
						s_d = put(s_d, rxb);
					end
				end else if (s_q.tmr == '0) begin
					s_d.rto = 1'b1;
					s_d = put(s_d, RES_RX_ERR);
					s_d.tmr = TMR_W'(ABORT_CYC);
					s_d.st = S_ABORT;
				end
			end
			S_PULSE: begin
				if (s_q.tmr == '0) begin
					s_d.pulse = 4'h0;
					s_d.st = S_IDLE;
				end
			end
			S_DUMP: begin
				if (s_q.idx[5:1] < 5'd16) begin
					item = s_q.ram[s_q.idx[4:1]];
				end else if (s_q.idx[4:1] == DUMP_IN) begin
					item = inport;
				end else if (s_q.idx[4:1] == DUMP_OUT) begin
					item = outport;
				end else begin
					item = {s_q.par, s_q.rto, s_q.tto, s_q.inh, s_q.st};
				end
				// Paced by the host: the next item waits until the last one is read
				if (!s_q.obf) begin
					s_d = put(s_d, hex_scan(s_q.idx[0] ? item[3:0] : item[7:4]));
					s_d.idx = s_q.idx + 6'd1;
					if (s_q.idx == DUMP_LAST) begin
						s_d.st = S_IDLE;
					end
				end
			end
			S_ABORT: begin
				// Link toggles fall back to zero; wait out the synchronisers
				s_d.txreq = 1'b0;
				if (s_q.tmr == '0) begin
					s_d.rx_seen = s_q.rt2;
					s_d.st = S_IDLE;
				end
			end
			default: s_d.st = S_IDLE;
		endcase
		// Host write last so a new byte is never lost
		if (io_wr_i && (io_addr_i == ADDR_DATA || io_addr_i == ADDR_CMD)) begin
			s_d.ibuf = io_wdata_i;
			s_d.ibf = 1'b1;
			s_d.cd = io_addr_i == ADDR_CMD;
		end
		// Advanced last, so a buffer load above only ever reads the second stage
		s_d.pin1 = {inhibit_switch_i, display_switch_i,
			keyboard_serial_clock_i, keyboard_serial_line_i};
		s_d.pin2 = s_q.pin1;
		s_d.abort = s_d.st == S_ABORT;
		s_d.clk_oe = s_d.cb[CB_DIS] || (s_d.obf && s_d.st == S_IDLE) ||
			(s_d.st == S_TXINH && s_d.tmr <= TMR_W'(INHIB_CYC / 2));
		s_d.rst_n = s_d.op[0] & ~s_d.pulse[0];
		s_d.a20 = s_d.op[1] & ~s_d.pulse[1];
		s_d.irq = s_d.obf & s_d.cb[CB_INT];
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '0;
			s_q.st <= S_IDLE;
			s_q.cb <= CB_RESET;
			s_q.op <= OP_RESET;
			s_q.rst_n <= OP_RESET[0];
			s_q.a20 <= OP_RESET[1];
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign io_rdata_o = s_q.rdata;
	assign keyboard_serial_clock_oe_o = s_q.clk_oe;
	assign keyboard_serial_line_oe_o = l_q.doe;
	// Open-drain: the pins are only ever pulled low
	assign keyboard_serial_clock_o = 1'b0;
	assign keyboard_serial_line_o = 1'b0;
	assign cpu_reset_n_o = s_q.rst_n;
	assign high_address_line_gate_o = s_q.a20;
	assign obuf_irq_o = s_q.irq;

	////////////////////////////////////////////////////////////////////////////
	AST_CMD_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && io_wr_i && io_addr_i == ADDR_CMD |=> s_q.ibf && s_q.cd &&
		s_q.ibuf == $past(io_wdata_i)) else $error("command write not marked");
	AST_DATA_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && io_wr_i && io_addr_i == ADDR_DATA |=> s_q.ibf && !s_q.cd)
		else $error("data write not marked");
	AST_OBUF_READ: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && io_rd_i && io_addr_i == ADDR_DATA |=> io_rdata_o == $past(s_q.obuf))
		else $error("output buffer read wrong");
	AST_RD_CB: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && s_q.st == S_IDLE && s_q.ibf && s_q.cd && s_q.ibuf == CMD_RD_CB
		|=> s_q.obf && s_q.obuf == $past(s_q.cb)) else $error("20h reply wrong");
	AST_SELF: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && s_q.st == S_IDLE && s_q.ibf && s_q.cd && s_q.ibuf == CMD_SELF
		|=> s_q.obf && s_q.obuf == RES_SELF_OK) else $error("self test reply wrong");
	AST_DISABLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && s_q.st == S_IDLE && s_q.ibf && s_q.cd && s_q.ibuf == CMD_DIS
		|=> s_q.cb[CB_DIS] && keyboard_serial_clock_oe_o) else $error("clock not held");
	AST_PULSE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && s_q.st == S_IDLE && s_q.ibf && s_q.cd && s_q.ibuf[7:4] == CMD_PULSE_HI
		&& !s_q.ibuf[0] |=> !cpu_reset_n_o && s_q.st == S_PULSE)
		else $error("reset pulse missing");
	AST_RESP_TMO: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && s_q.st == S_RESP && s_q.tmr == '0 && s_q.rt2 == s_q.rx_seen
		|=> s_q.tto && s_q.rto && s_q.obuf == RES_TX_ERR) else $error("reply time-out");
	AST_INHIBIT: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && !s_q.obf ##1 s_q.obf |-> s_q.inh == $past(s_q.pin2[3]))
		else $error("inhibit bit not refreshed");
	AST_LINK_STOP: assert property (@(negedge keyboard_serial_clock_i)
		disable iff (!lnk_rst_n)
		l_q.tx && l_q.cnt == FR_STOP |=> !keyboard_serial_line_oe_o && l_q.cnt == FR_ACK)
		else $error("stop bit driven");
endmodule

// ### kbc_kbd_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
// Keyboard end of the link; its clock runs only inside frames
// and both lines idle high through the pull-ups
module kbc_kbd_model #(
	parameter int HALF = 32
) (
	input  wire logic clk_line_i,
	input  wire logic data_line_i,
	output logic      clk_low_o,
	output logic      data_low_o
);
	int         mode = 0; // 0 reply, 1 never clock, 2 silent, 3 bad parity reply
	int         n_rx = 0;
	logic [7:0] rx_q;
	logic       par_ok;
	logic [9:0] sh;
	initial begin
		clk_low_o = 0;
		data_low_o = 0;
	end
	task automatic pulse;
		#HALF clk_low_o = 1;
		#HALF clk_low_o = 0;
	endtask
	task automatic send_frame(input logic [7:0] b, input logic bad, input logic cut);
		logic [10:0] f;
		f = {1'b1, ~^b ^ bad, b, 1'b0};
		for (int k = 0; k < (cut ? 5 : 11); k++) begin
			data_low_o = !f[k];
			pulse();
		end
		data_low_o = 0;
	endtask
	////////////////////////////////////////////////////////////////
	// Request: controller holds clock low, then data low
	always @(negedge data_line_i) begin
		if (!clk_line_i && !data_low_o) begin
			for (int i = 0; i < 3000 && !clk_line_i; i++) #10;
			if (mode != 1) begin
				for (int k = 0; k < 10; k++) begin
					pulse();
					sh[k] = data_line_i;
				end
				data_low_o = 1;
				pulse();
				data_low_o = 0;
				n_rx++;
				rx_q = sh[7:0];
				par_ok = ^sh[8:0] & sh[9];
				if (mode != 2) begin
					#1000;
					send_frame(8'hfa, mode == 3, 1'b0);
				end
			end
		end
	end
endmodule

// ### kbc_top_tb_top.sv
`timescale 1ns/1ns
module kbc_top_tb_top;
	import kbc_pkg::*;
	localparam int PUL = 50;
	logic       clk_i = 0;
	logic       resetn_i = 0;
	logic       rd = 0;
	logic       wrs = 0;
	logic       ce = 1;
	logic       inh = 1;
	logic       disp = 0;
	logic [7:0] addr = 0;
	logic [7:0] wd = 0;
	logic [7:0] rdata, st, v, b;
	logic       c_oe, c_o, d_oe, d_o, m_cl, m_dl, rst_n, gate, irq;
	int         err_total = 0;
	int         n_tests = 0;
	int         seed = 97;
	logic [7:0] q[$];
	logic [7:0] fd[6] = '{8'h1c, 8'h1c, 8'h1c, 8'hf0, 8'h1c, 8'h1c};
	logic [7:0] fe[6] = '{8'h1c, 8'hff, 8'hff, 8'h00, 8'h9c, 8'h1c};
	wire        kclk = !(c_oe | m_cl);
	wire        kdat = !(d_oe | m_dl);

	always #5 clk_i = ~clk_i;

	kbc_top #(.START_CYC(200), .FINISH_CYC(100), .RESP_CYC(300), .PULSE_CYC(PUL),
		.INHIB_CYC(40)) uut (
		.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .io_addr_i(addr), .io_rd_i(rd),
		.io_wr_i(wrs), .io_wdata_i(wd), .io_rdata_o(rdata),
		.keyboard_serial_clock_i(kclk), .keyboard_serial_clock_o(c_o),
		.keyboard_serial_clock_oe_o(c_oe), .keyboard_serial_line_i(kdat),
		.keyboard_serial_line_o(d_o), .keyboard_serial_line_oe_o(d_oe),
		.inhibit_switch_i(inh), .display_switch_i(disp), .cpu_reset_n_o(rst_n),
		.high_address_line_gate_o(gate), .obuf_irq_o(irq));
	kbc_kbd_model #(.HALF(32)) kbd (.clk_line_i(kclk), .data_line_i(kdat),
		.clk_low_o(m_cl), .data_low_o(m_dl));

	////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task tmo;
		err_total++;
		final_report();
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task rdx(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1 addr = a;
		rd = 1;
		@(posedge clk_i);
		#1 rd = 0;
		d = rdata;
	endtask
	// No status poll here, so a scenario can catch the input-full flag
	task wraw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1 addr = a;
		wd = d;
		wrs = 1;
		@(posedge clk_i);
		#1 wrs = 0;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		int i;
		for (i = 0; i < 900; i++) begin
			rdx(ADDR_CMD, st);
			if (!st[1]) break;
		end
		if (i == 900) tmo();
		else wraw(a, d);
	endtask
	task get(output logic [7:0] d);
		int i;
		for (i = 0; i < 2000; i++) begin
			rdx(ADDR_CMD, st);
			if (st[0]) break;
		end
		if (i == 2000) tmo();
		else rdx(ADDR_DATA, d);
	endtask
	task stchk(input logic [7:0] m, input logic [7:0] e);
		rdx(ADDR_CMD, st);
		chk("status", st & m, e);
	endtask
	// Replies queue up in issue order, as the host sees them
	task cmdx(input logic [7:0] c, input logic [7:0] m, input logic [7:0] e);
		q.push_back(e);
		wr(ADDR_CMD, c);
		get(v);
		chk("reply", v & m, q.pop_front());
	endtask
	task setcb(input logic [7:0] d);
		wr(ADDR_CMD, CMD_WR_CB);
		wr(ADDR_DATA, d);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		disp = 1'($random(seed));
		cyc(6);
		resetn_i = 1;
		chk("reset pins", {rst_n, gate, irq, c_oe}, 8'h0c);
		chk("drive levels", {c_o, d_o}, 8'h00);
		rdx(8'h61, v);
		chk("unmapped", v, 8'h00);
		cmdx(CMD_RD_CB, 8'hff, CB_RESET);
		for (int c = 0; c < 16; c++) begin
			wr(ADDR_CMD, {CMD_PULSE_HI, c[3:0]});
			cyc(PUL / 2);
			chk("pulse", {gate, rst_n}, c[1:0]);
			cyc(PUL);
			chk("pulse end", {gate, rst_n}, 8'h03);
		end
		wr(ADDR_CMD, 8'hfe);
		wraw(ADDR_CMD, CMD_SELF);
		stchk(8'h0b, 8'h0a);
		get(v);
		chk("self test", v, RES_SELF_OK);
		stchk(8'h03, 8'h00);
		inh = 0;
		cmdx(CMD_RD_IN, 8'hc0, {1'b0, disp, 6'h0});
		stchk(8'h10, 8'h00);
		inh = 1;
		cmdx(CMD_SELF, 8'hff, RES_SELF_OK);
		stchk(8'h10, 8'h10);
		cmdx(CMD_LINE, 8'hff, RES_LINE_OK);
		cmdx(CMD_RD_TEST, 8'h03, 8'h03);
		b = 8'(($random(seed) & 8'h4c) | 8'h01);
		setcb(b);
		stchk(8'h0c, b & 8'h04);
		cmdx(CMD_RD_CB, 8'hff, b);
		wr(ADDR_CMD, CMD_SELF);
		cyc(5);
		chk("irq", irq, 8'h01);
		get(v);
		cyc(1);
		chk("irq", irq, 8'h00);
		wr(ADDR_CMD, CMD_WR_OUT);
		wr(ADDR_DATA, 8'h01);
		cyc(3);
		chk("out pins", {gate, rst_n}, 8'h01);
		cmdx(CMD_RD_OUT, 8'h03, 8'h01);
		chk("sent", kbd.n_rx[7:0], 8'h00);
		wr(ADDR_CMD, CMD_WR_OUT);
		wr(ADDR_DATA, 8'h03);
		wr(ADDR_CMD, CMD_DIS);
		cmdx(CMD_RD_CB, 8'h10, 8'h10);
		chk("clock held", kclk, 8'h00);
		cmdx(CMD_RD_TEST, 8'h03, 8'h02);
		wr(ADDR_DATA, 8'h5a);
		get(v);
		chk("refused", v, RES_TX_ERR);
		wr(ADDR_CMD, CMD_ENA);
		cmdx(CMD_RD_CB, 8'h10, 8'h00);
		chk("clock free", kclk, 8'h01);
		setcb(8'h00);
		// Normal send, then each way the keyboard can fail it
		for (int m = 0; m < 4; m++) begin
			b = 8'($random(seed));
			kbd.mode = m;
			wr(ADDR_DATA, b);
			get(v);
			chk("send reply", v, m == 0 ? 8'hfa : RES_TX_ERR);
			stchk(8'he0, {m == 3, m == 2, m != 0, 5'h0});
			if (m == 0) chk("kbd byte", kbd.rx_q, b);
			if (m == 0) chk("kbd frame", kbd.par_ok, 8'h01);
		end
		for (int k = 0; k < 6; k++) begin
			if (k == 3) setcb(8'h40);
			if (k == 5) setcb(8'h20);
			#7 kbd.send_frame(fd[k], k == 1 || k == 5, k == 2);
			if (k != 3) begin
				get(v);
				chk("scan", v, fe[k]);
			end
			if (k < 3) stchk({k != 2, 7'h40}, {k == 1, k == 2, 6'h0});
		end
		setcb(8'h00);
		inh = 0;
		kbd.send_frame(8'h1d, 1'b0, 1'b0);
		cyc(100);
		stchk(8'h01, 8'h00);
		setcb(8'h08);
		kbd.send_frame(8'h1d, 1'b0, 1'b0);
		get(v);
		chk("override", v, 8'h1d);
		inh = 1;
		wr(ADDR_CMD, CMD_DUMP);
		for (int k = 0; k < 38; k++) get(v);
		cyc(60);
		stchk(8'h01, 8'h00);
		// Clock enable low: a write must leave no trace
		ce = 0;
		wraw(ADDR_CMD, CMD_SELF);
		cyc(3);
		ce = 1;
		stchk(8'h03, 8'h00);
		final_report();
	end
	initial begin
		#900000;
		tmo();
	end
endmodule
